// ---- inc/tpoc_pkg.sv ----
package tpoc_pkg;
  localparam int unsigned GROUPS  = 4;
  localparam int unsigned GROUP_W = 4;
  localparam int unsigned PINS    = 16;
  localparam int unsigned CHANS   = 4;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned DATA_W  = 32;

  localparam logic [ADDR_W-1:0] OFS_MODE    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TSEL    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAGED  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_PORT    = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DIR     = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_PIN     = 5'h18;

  localparam logic [7:0]  MODE_RST   = 8'hf0;
  localparam logic [3:0]  MODE_FIXED = 4'hf;
  localparam logic [7:0]  TSEL_RST   = 8'hff;
  localparam logic [15:0] HALF_RST   = 16'h0000;
  localparam logic [1:0]  SEL_CH0    = 2'b00;
  localparam logic [1:0]  SEL_CH3    = 2'b11;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : tpoc_pkg

// ---- verilog/tpoc_group.sv ----
`timescale 1ns/1ns
module tpoc_group
  import tpoc_pkg::*;
(
  input  wire logic               trig_a,
  input  wire logic               trig_b,
  input  wire logic [GROUP_W-1:0] staged,
  input  wire logic [GROUP_W-1:0] enable,
  input  wire logic [GROUP_W-1:0] cur,
  output logic      [GROUP_W-1:0] nxt
);
  logic [GROUP_W-1:0] take;

  // match a moves every enabled staged bit; match b only the enabled zeros
  always_comb begin
    take = enable & ({GROUP_W{trig_a}} | ({GROUP_W{trig_b}} & ~staged)); // [R15] [R16]
    nxt  = (cur & ~take) | (staged & take); // [R9] [R10]
  end
endmodule : tpoc_group

// ---- verilog/tpoc_top.sv ----
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
// How it works
// R1: group select 01, 10, 11 picks timer channel 1, 2, 3; 11 after reset.
// R2: group select 00 picks timer channel 0 as trigger source.
// R3: mode register loads f0 on reset and hardware standby; kept otherwise.
// R4: mode register upper four bits read one and ignore writes.
// R5: mode bit per group; zero means outputs change only on match a.
// R6: mode bit one drives zeros and ones separately using matches a and b.
// R7: software puts period in compare b and margin in compare a.
// R8: pin carries pattern only when direction and enable bits are both set.
// R9: pin shows port bit first; each trigger copies staged bit into it.
// R10: enabled input pin: port bit read-only, still updated; disabled pin ordinary.
// R11: software writes next pattern before the following trigger event.
// R12: compare a in capture mode makes capture the trigger instead.
// R13: timer-owned pin carries no pattern, transfer still happens.
// R14: software changes pin functions only while no trigger can occur.
// R15: in non-overlap mode match a copies every staged bit.
// R16: in non-overlap mode match b copies only zero bits.
// R17: software leaves staged data alone between match b and match a.
// R18: each trigger pulse gives exactly one transfer, on its sampling edge.
module tpoc_top
  import tpoc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              hw_standby,
  input  wire logic [CHANS-1:0]  cmp_a_match,
  input  wire logic [CHANS-1:0]  cmp_b_match,
  input  wire logic [CHANS-1:0]  capture_a,
  input  wire logic [CHANS-1:0]  compare_a_is_capture,
  input  wire logic [PINS-1:0]   timer_owns_pin,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  logic              reg_rst;
  logic [7:0]        mode_q;
  logic [7:0]        tsel_q;
  logic [PINS-1:0]   staged_q;
  logic [PINS-1:0]   enable_q;
  logic [PINS-1:0]   port_out_q;
  logic [PINS-1:0]   port_out_d;
  logic [PINS-1:0]   port_dir_q;
  logic [PINS-1:0]   pin_in_q;
  logic [PINS-1:0]   pin_out_q;
  logic [PINS-1:0]   pin_oe_q;
  logic [CHANS-1:0]  chan_a;
  logic [GROUPS-1:0] grp_a;
  logic [GROUPS-1:0] grp_b;
  logic [PINS-1:0]   mask_a;
  logic [PINS-1:0]   mask_b;
  logic [PINS-1:0]   port_xfer;
  logic              awready_q;
  logic              aw_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              wready_q;
  logic              w_got_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              do_wr;
  logic [DATA_W-1:0] rd_val;

  // standby clears the same registers as chip reset except the AXI handshake flops, which only rst clears; software standby is not modelled
  assign reg_rst = rst | hw_standby;

  function automatic logic pick_chan(input logic [1:0] sel, input logic [CHANS-1:0] v);
    return v[sel];
  endfunction : pick_chan

  function automatic logic [PINS-1:0] wr16(input logic [PINS-1:0]   old,
                                           input logic [DATA_W-1:0] data,
                                           input logic [3:0]        strb);
    logic [PINS-1:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : wr16

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_MODE) || (a == OFS_TSEL) || (a == OFS_STAGED) || (a == OFS_ENABLE) ||
           (a == OFS_PORT) || (a == OFS_DIR) || (a == OFS_PIN);
  endfunction : is_mapped

  assign chan_a = (compare_a_is_capture & capture_a) | (~compare_a_is_capture & cmp_a_match); // [R12]

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    assign grp_a[g] = pick_chan(tsel_q[2*g +: 2], chan_a); // [R1] [R2] [R18]
    // match b is only heard in non-overlap groups
    assign grp_b[g] = pick_chan(tsel_q[2*g +: 2], cmp_b_match) & mode_q[g]; // [R5] [R6]
    assign mask_a[GROUP_W*g +: GROUP_W] = {GROUP_W{grp_a[g]}};
    assign mask_b[GROUP_W*g +: GROUP_W] = {GROUP_W{grp_b[g]}};
    tpoc_group u_grp (
      .trig_a (grp_a[g]),
      .trig_b (grp_b[g]),
      .staged (staged_q[GROUP_W*g +: GROUP_W]),
      .enable (enable_q[GROUP_W*g +: GROUP_W]),
      .cur    (port_out_q[GROUP_W*g +: GROUP_W]),
      .nxt    (port_xfer[GROUP_W*g +: GROUP_W])
    );
  end

  assign do_wr = aw_got_q & w_got_q & ~bvalid_q;

  // enabled bits belong to the transfer path, so software cannot disturb them
  always_comb begin
    port_out_d = port_xfer;
    if (do_wr && awaddr_q == OFS_PORT) begin
      port_out_d = (port_xfer & enable_q) | (wr16(port_out_q, wdata_q, wstrb_q) & ~enable_q); // [R10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      port_out_q <= HALF_RST;
    end else begin
      port_out_q <= port_out_d; // [R9] [R13] [R18]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      mode_q     <= MODE_RST; // [R3]
      tsel_q     <= TSEL_RST; // [R1]
      staged_q   <= HALF_RST;
      enable_q   <= HALF_RST;
      port_dir_q <= HALF_RST;
    end else if (do_wr) begin
      case (awaddr_q)
        OFS_MODE: begin
          if (wstrb_q[0]) begin
            mode_q <= {MODE_FIXED, wdata_q[3:0]}; // [R4]
          end
        end
        OFS_TSEL: begin
          if (wstrb_q[0]) begin
            tsel_q <= wdata_q[7:0];
          end
        end
        OFS_STAGED: staged_q   <= wr16(staged_q, wdata_q, wstrb_q);
        OFS_ENABLE: enable_q   <= wr16(enable_q, wdata_q, wstrb_q);
        OFS_DIR:    port_dir_q <= wr16(port_dir_q, wdata_q, wstrb_q);
        default: begin
        end
      endcase
    end
  end

  // pins lag the port bit by one edge so outputs come from flops
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      pin_out_q <= HALF_RST;
      pin_oe_q  <= HALF_RST;
      pin_in_q  <= HALF_RST;
    end else begin
      pin_out_q <= port_out_q;
      pin_oe_q  <= port_dir_q & ~timer_owns_pin; // [R8] [R13]
      pin_in_q  <= pin_in;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe  = pin_oe_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awready_q <= 1'b1;
      aw_got_q  <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wready_q <= 1'b1;
      w_got_q  <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rd_val = '0;
    case (s_axi_araddr)
      OFS_MODE:   rd_val[7:0]  = mode_q;
      OFS_TSEL:   rd_val[7:0]  = tsel_q;
      OFS_STAGED: rd_val[15:0] = staged_q;
      OFS_ENABLE: rd_val[15:0] = enable_q;
      OFS_PORT:   rd_val[15:0] = port_out_q;
      OFS_DIR:    rd_val[15:0] = port_dir_q;
      OFS_PIN:    rd_val[15:0] = pin_in_q;
      default:    rd_val       = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_val;
      rresp_q   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  property p_mode_fixed;
    @(posedge clk_sys) disable iff (reg_rst)
      (mode_q[7:4] == MODE_FIXED) && (tsel_q == $past(tsel_q) || $past(do_wr));
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode upper bits not ones"); // [R4]

  property p_mode_reset;
    @(posedge clk_sys) $past(reg_rst) |-> (mode_q == MODE_RST) && (tsel_q == TSEL_RST);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("bad reset value"); // [R3] [R1]

  property p_grp0_ch0;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) && $past(tsel_q[1:0] == SEL_CH0 && chan_a[0] && enable_q[3:0] == 4'hf)
      |-> port_out_q[3:0] == $past(staged_q[3:0]);
  endproperty
  a_grp0_ch0: assert property (p_grp0_ch0) else $error("channel 0 trigger missed"); // [R2]

  property p_trig_a_all;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) |-> ((port_out_q ^ $past(staged_q)) & $past(mask_a & enable_q)) == '0;
  endproperty
  a_trig_a_all: assert property (p_trig_a_all) else $error("match a transfer wrong"); // [R9] [R15]

  property p_b_zeros;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) |-> (port_out_q & $past(mask_b & enable_q & ~staged_q)) == '0;
  endproperty
  a_b_zeros: assert property (p_b_zeros) else $error("zero not moved at match b"); // [R16] [R6]

  property p_hold_untriggered;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) |-> ((port_out_q ^ $past(port_out_q)) &
        $past(enable_q & ~mask_a & ~(mask_b & ~staged_q))) == '0;
  endproperty
  a_hold_untriggered: assert property (p_hold_untriggered) else $error("port bit moved"); // [R10] [R16]

  property p_normal_b_ignored;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) && $past(!mode_q[0] && !grp_a[0] && enable_q[3:0] == 4'hf)
      |-> port_out_q[3:0] == $past(port_out_q[3:0]);
  endproperty
  a_normal_b_ignored: assert property (p_normal_b_ignored) else $error("normal group moved"); // [R5]

  property p_capture_trig;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) && $past(compare_a_is_capture[3] && tsel_q[1:0] == SEL_CH3 &&
        capture_a[3] && enable_q[0]) |-> port_out_q[0] == $past(staged_q[0]);
  endproperty
  a_capture_trig: assert property (p_capture_trig) else $error("capture trigger missed"); // [R12]

  property p_pin_follow;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) && !$past(reg_rst, 2) |->
        ((pin_out_q ^ $past(staged_q, 2)) & $past(mask_a & enable_q, 2)) == '0;
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin missed pattern"); // [R8] [R18]

  property p_timer_owned;
    @(posedge clk_sys) disable iff (reg_rst)
      !$past(reg_rst) |-> (pin_oe_q & $past(timer_owns_pin)) == '0 &&
        (pin_oe_q == $past(port_dir_q & ~timer_owns_pin));
  endproperty
  a_timer_owned: assert property (p_timer_owned) else $error("timer pin driven"); // [R13]
endmodule : tpoc_top

// ---- tb/tpoc_timer_model.sv ----
`timescale 1ns/1ns
// timer side: one-cycle event pulses on request, kind 0 a, 1 b, 2 capture
module tpoc_timer_model
  import tpoc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ev_go,
  input  wire logic [1:0]       ev_ch,
  input  wire logic [1:0]       ev_kind,
  output logic      [CHANS-1:0] cmp_a_match,
  output logic      [CHANS-1:0] cmp_b_match,
  output logic      [CHANS-1:0] capture_a
);
  // b before a gives the margin; caller spaces them
  always_ff @(posedge clk_sys) begin
    cmp_a_match <= '0;
    cmp_b_match <= '0;
    capture_a   <= '0;
    if (!rst && ev_go) begin
      case (ev_kind)
        2'h0: cmp_a_match[ev_ch] <= 1'b1;
        2'h1: cmp_b_match[ev_ch] <= 1'b1;
        default: capture_a[ev_ch] <= 1'b1;
      endcase
    end
  end
endmodule : tpoc_timer_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench
  import tpoc_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              hw_standby = 1'b0;
  logic [CHANS-1:0]  cap_sel = '0;
  logic [CHANS-1:0]  ca, cb, cc;
  logic [PINS-1:0]   own = '0;
  logic [PINS-1:0]   ext = 16'h8001;
  logic [PINS-1:0]   pin_out, pin_oe;
  wire  [PINS-1:0]   pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
  logic              ev_go = 1'b0;
  logic [1:0]        ev_ch = 2'h0, ev_kind = 2'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd_v;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, wr_r, rd_r;
  int                miscompares = 0, num_checks = 0;

  always #5 clk_sys = ~clk_sys;

  tpoc_timer_model u_tpoc_timer_model (.clk_sys(clk_sys), .rst(rst), .ev_go(ev_go),
    .ev_ch(ev_ch), .ev_kind(ev_kind), .cmp_a_match(ca), .cmp_b_match(cb), .capture_a(cc));

  tpoc_top u_tpoc_top (.clk_sys(clk_sys), .rst(rst), .hw_standby(hw_standby),
    .cmp_a_match(ca), .cmp_b_match(cb), .capture_a(cc), .compare_a_is_capture(cap_sel),
    .timer_owns_pin(own), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task hang;
    miscompares++;
    $display("MISMATCH handshake exp done got timeout");
    test_done();
  endtask : hang

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    wr_r = bresp;
    bready <= 1'b0;
    if (n >= 100) hang();
  endtask : wr

  task rc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    if (n >= 100) hang();
    chk(nm, e, rd_v);
  endtask : rc

  // one pulse, then time for port and pin to settle
  task ev(input int ch, input int k);
    @(posedge clk_sys);
    ev_go <= 1'b1;
    ev_ch <= 2'(ch);
    ev_kind <= 2'(k);
    @(posedge clk_sys);
    ev_go <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : ev

  task t_reset;
    rc("mode", OFS_MODE, 32'hf0);
    rc("tsel", OFS_TSEL, 32'hff);
    wr(OFS_MODE, 32'h0000_0003);
    rc("mode", OFS_MODE, 32'hf3);
    chk("bresp_ok", 32'(RESP_OKAY), 32'(wr_r));
    chk("rresp_ok", 32'(RESP_OKAY), 32'(rd_r));
    wr(5'h1c, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(wr_r));
    rc("unmapped", 5'h1c, 32'h0);
    chk("rresp", 32'(RESP_SLVERR), 32'(rd_r));
    wr(OFS_MODE, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // setup only between pulses, never during one
  task t_select;
    logic [31:0] prev;
    prev = 32'h0;
    wr(OFS_ENABLE, 32'h000f);
    wr(OFS_DIR, 32'h000f);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_TSEL, {24'h0, 6'h3f, 2'(s)});
      wr(OFS_STAGED, 32'(s + 9));
      ev(s, 1);
      ev((s + 1) % 4, 0);
      rc("port_hold", OFS_PORT, prev);
      ev(s, 0);
      rc("port_sel", OFS_PORT, 32'(s + 9));
      chk("pin_out", 32'(s + 9), 32'(pin_out[3:0]));
      chk("pin_oe", 32'hf, 32'(pin_oe[3:0]));
      prev = 32'(s + 9);
    end
    $display("test select done");
  endtask : t_select

  // staged data left alone from match b to match a
  task t_nov;
    wr(OFS_MODE, 32'h1);
    rc("mode", OFS_MODE, 32'hf1);
    wr(OFS_STAGED, 32'h5);
    ev(3, 1);
    rc("port_b", OFS_PORT, 32'h4);
    ev(3, 0);
    rc("port_a", OFS_PORT, 32'h5);
    wr(OFS_MODE, 32'h0);
    $display("test nonoverlap done");
  endtask : t_nov

  task t_capture;
    @(posedge clk_sys);
    cap_sel <= 4'h8;
    wr(OFS_STAGED, 32'ha);
    ev(3, 0);
    rc("port_cmp", OFS_PORT, 32'h5);
    ev(3, 2);
    rc("port_cap", OFS_PORT, 32'ha);
    cap_sel <= 4'h0;
    $display("test capture done");
  endtask : t_capture

  task t_pins;
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_PORT, 32'h00a0);
    rc("port_plain", OFS_PORT, 32'h00a0);
    wr(OFS_ENABLE, 32'h00f0);
    wr(OFS_DIR, 32'h0030);
    own <= 16'h0010;
    wr(OFS_PORT, 32'h0050);
    rc("port_ro", OFS_PORT, 32'h00a0);
    wr(OFS_STAGED, 32'h0050);
    ev(3, 0);
    rc("port_trig", OFS_PORT, 32'h0050);
    chk("pin_oe", 32'h0020, 32'(pin_oe));
    chk("pin_out", 32'h0050, 32'(pin_out));
    rc("pin_rd", OFS_PIN, 32'h8001);
    $display("test pins done");
  endtask : t_pins

  task t_standby;
    wr(OFS_MODE, 32'h2);
    @(posedge clk_sys);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hw_standby <= 1'b0;
    rc("mode", OFS_MODE, 32'hf0);
    rc("port", OFS_PORT, 32'h0);
    rc("tsel", OFS_TSEL, 32'hff);
    chk("pin_oe_sb", 32'h0, 32'(pin_oe));
    chk("pin_out_sb", 32'h0, 32'(pin_out));
    $display("test standby done");
  endtask : t_standby

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_select();
    t_nov();
    t_capture();
    t_pins();
    t_standby();
    test_done();
  end
endmodule : testbench
